// >>> shared/wdmc_pkg.sv
// Constants, field layout and types for the watchdog mode control block.
// Assumes the CPU core presents expanded-register writes as bank, address and data.
package wdmc_pkg;

  // Mode register location: bank F of the expanded register group
  localparam logic [3:0] WDMC_BANK_F    = 4'hF;
  localparam logic [7:0] WDMC_MODE_ADDR = 8'h0F;

  // Mode register field layout (bits 7:5 are reserved and not stored)
  localparam int WDMC_MODE_W    = 5;
  localparam int WDMC_TSEL_LO   = 0;
  localparam int WDMC_TSEL_HI   = 1;
  localparam int WDMC_IDLE_BIT  = 2;
  localparam int WDMC_SLEEP_BIT = 3;
  localparam int WDMC_CLK_BIT   = 4;

  // Reset value: crystal select 0, sleep 1, idle 1, time select 01
  localparam logic [4:0] WDMC_MODE_RESET = 5'h0D;
  localparam logic [1:0] WDMC_TSEL_20MS  = 2'h1;

  // Crystal-clock taps, in input clock periods
  localparam int WDMC_XT_TAP0 = 512;
  localparam int WDMC_XT_TAP1 = 1024;
  localparam int WDMC_XT_TAP2 = 2048;
  localparam int WDMC_XT_TAP3 = 8192;

  // RC-oscillator minimum time-outs, in milliseconds
  localparam int WDMC_RC_MS0 = 10;
  localparam int WDMC_RC_MS1 = 20;
  localparam int WDMC_RC_MS2 = 40;
  localparam int WDMC_RC_MS3 = 160;

  // Write window: processor cycles and crystal clocks per processor cycle
  localparam int WDMC_WIN_CYCLES   = 64;
  localparam int WDMC_XTAL_PER_CYC = 2;
  localparam int WDMC_WIN_XTAL     = WDMC_WIN_CYCLES * WDMC_XTAL_PER_CYC;
  localparam int WDMC_WIN_W        = 8;

  // Counter width, wide enough for the longest RC tap
  localparam int WDMC_CNT_W = 20;

  // Program restart address after a watchdog reset
  localparam logic [15:0] WDMC_RESTART_ADDR = 16'h000C;

  // Processor flag positions in the flag register
  localparam int WDMC_FLAG_C = 7;
  localparam int WDMC_FLAG_Z = 6;
  localparam int WDMC_FLAG_S = 5;
  localparam int WDMC_FLAG_V = 4;
  localparam int WDMC_FLAG_D = 3;
  localparam int WDMC_FLAG_H = 2;

  // Values the refresh leaves in the flags it alters
  localparam logic WDMC_REFRESH_Z = 1'b1;
  localparam logic WDMC_REFRESH_S = 1'b0;
  localparam logic WDMC_REFRESH_V = 1'b0;

  // Write window states
  typedef enum logic [1:0] {
    WDMC_WAIT_FIRST,
    WDMC_WIN_OPEN,
    WDMC_WIN_CLOSED
  } wdmc_win_t;

endpackage

// >>> hw/wdmc_sync.sv
// Two-flip-flop synchroniser for pin inputs of the watchdog mode control block.
// Assumes the inputs are asynchronous to mclk and slow against it.
`timescale 1ns/1ps
`default_nettype none

module wdmc_sync #(
  parameter int W = 2
) (
  input  wire logic         mclk,   // System clock
  input  wire logic         arst_n, // Asynchronous reset, active low
  input  wire logic [W-1:0] d,      // Asynchronous inputs
  output var  logic [W-1:0] q       // Synchronised outputs
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } wdmc_sync_t;

  wdmc_sync_t s;
  wdmc_sync_t next_s;

  always_comb begin
    next_s        = s;
    next_s.stage1 = d;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.stage2;

endmodule

`default_nettype wire

// >>> hw/wdmc_top.sv
// Watchdog timer with mode register writable only while its window is open, clock selection and sleep gating.
// Assumes the CPU core drives register writes, refresh strobes and power-mode levels
// on mclk; the RC oscillator and crystal input arrive as asynchronous pins.
`timescale 1ns/1ps
`default_nettype none

module wdmc_top
  import wdmc_pkg::*;
#(
  parameter int RC_OSC_KHZ = 100
) (
  input  wire logic        mclk,              // System clock, 40 MHz
  input  wire logic        arst_n,            // Asynchronous reset, active low
  input  wire logic        rc_osc_pin,        // On-board RC oscillator output
  input  wire logic        crystal_input_pin, // Crystal input clock
  input  wire logic [3:0]  reg_bank,          // Expanded register bank of a write
  input  wire logic [7:0]  reg_addr,          // Register address of a write
  input  wire logic [7:0]  reg_wdata,         // Register write data
  input  wire logic        reg_we,            // Register write strobe
  input  wire logic        refresh_exec,      // Refresh instruction executed
  input  wire logic [7:0]  flags_in,          // Current processor flags
  input  wire logic        first_instr,       // First instruction after reset or recovery
  input  wire logic        sleep_recovery,    // Sleep recovery event
  input  wire logic        cpu_idle,          // Clock-gated idle mode active
  input  wire logic        cpu_sleep,         // Oscillator-off sleep mode active
  output var  logic [7:0]  flags_out,         // Flags after a refresh
  output var  logic        flags_we,          // Flags write strobe
  output var  logic        wdt_reset,         // Watchdog reset pulse
  output var  logic        por_start,         // Power-on reset delay trigger
  output var  logic        sleep_exit,        // Sleep ended by time-out
  output var  logic [15:0] restart_addr,      // Program restart address
  output var  logic        por_clk_sel,       // Counter clock: 1 crystal, 0 RC
  output var  logic        crystal_keep_on,   // Keep crystal running in sleep
  output var  logic        wdt_running        // Watchdog enabled
);

  typedef struct packed {
    logic [WDMC_MODE_W-1:0] mode;
    wdmc_win_t              win_st;
    logic [WDMC_WIN_W-1:0]  win_cnt;
    logic                   enabled;
    logic [WDMC_CNT_W-1:0]  count;
    logic                   rc_dly;
    logic                   xt_dly;
    logic                   wdt_reset;
    logic                   por_start;
    logic                   sleep_exit;
    logic [15:0]            restart_addr;
    logic [7:0]             flags_out;
    logic                   flags_we;
    logic                   crystal_keep_on;
    logic                   por_clk_sel;
  } wdmc_state_t;

  wdmc_state_t s;
  wdmc_state_t next_s;

  logic [1:0] pins_sync;
  logic       rc_s;
  logic       xt_s;

  wdmc_sync #(
    .W (2)
  ) wdmc_sync_inst (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      ({crystal_input_pin, rc_osc_pin}),
    .q      (pins_sync)
  );

  assign rc_s = pins_sync[0];
  assign xt_s = pins_sync[1];

  // Terminal count for a time select code and clock source
  function automatic logic [WDMC_CNT_W-1:0] tap_limit(
    input logic [1:0] sel,
    input logic       use_xtal
  );
    int lim;
    lim = 0;
    if (use_xtal) begin
      case (sel)
        2'h0:    lim = WDMC_XT_TAP0;
        2'h1:    lim = WDMC_XT_TAP1;
        2'h2:    lim = WDMC_XT_TAP2;
        default: lim = WDMC_XT_TAP3;
      endcase
    end else begin
      case (sel)
        2'h0:    lim = WDMC_RC_MS0 * RC_OSC_KHZ;
        2'h1:    lim = WDMC_RC_MS1 * RC_OSC_KHZ;
        2'h2:    lim = WDMC_RC_MS2 * RC_OSC_KHZ;
        default: lim = WDMC_RC_MS3 * RC_OSC_KHZ;
      endcase
    end
    return WDMC_CNT_W'(lim);
  endfunction

  logic                  rc_edge;
  logic                  xt_edge;
  logic                  use_xtal;
  logic                  clk_edge;
  logic                  gate_ok;
  logic                  mode_hit;
  logic                  timeout;
  logic [WDMC_CNT_W-1:0] limit;
  logic [WDMC_CNT_W-1:0] count_inc;

  always_comb begin
    rc_edge   = rc_s & ~s.rc_dly;
    xt_edge   = xt_s & ~s.xt_dly;
    use_xtal  = s.mode[WDMC_CLK_BIT];
    clk_edge  = use_xtal ? xt_edge : rc_edge;
    limit     = tap_limit(s.mode[WDMC_TSEL_HI:WDMC_TSEL_LO], use_xtal);
    count_inc = s.count + WDMC_CNT_W'(1);

    // Idle and sleep suspend counting unless their bits say otherwise
    gate_ok = 1'b1;
    if (cpu_idle && !s.mode[WDMC_IDLE_BIT]) begin
      gate_ok = 1'b0;
    end
    if (cpu_sleep && !s.mode[WDMC_SLEEP_BIT]) begin
      gate_ok = 1'b0;
    end

    // A refresh in the same cycle as the terminal count wins
    timeout = s.enabled && gate_ok && clk_edge && !refresh_exec
              && (count_inc >= limit);

    mode_hit = reg_we && (reg_bank == WDMC_BANK_F)
               && (reg_addr == WDMC_MODE_ADDR);
  end

  always_comb begin
    next_s            = s;
    next_s.rc_dly     = rc_s;
    next_s.xt_dly     = xt_s;
    next_s.wdt_reset  = 1'b0;
    next_s.por_start  = 1'b0;
    next_s.sleep_exit = 1'b0;
    next_s.flags_we   = 1'b0;

    // Write window
    case (s.win_st)
      WDMC_WAIT_FIRST: begin
        if (first_instr) begin
          next_s.win_st  = WDMC_WIN_OPEN;
          next_s.win_cnt = '0;
        end
      end
      WDMC_WIN_OPEN: begin
        if (xt_edge) begin
          if (s.win_cnt == WDMC_WIN_W'(WDMC_WIN_XTAL - 1)) begin
            next_s.win_st = WDMC_WIN_CLOSED;
          end else begin
            next_s.win_cnt = s.win_cnt + WDMC_WIN_W'(1);
          end
        end
      end
      WDMC_WIN_CLOSED: begin
        next_s.win_st = WDMC_WIN_CLOSED;
      end
      default: begin
        next_s.win_st = WDMC_WAIT_FIRST;
      end
    endcase

    // Mode write, accepted only while the window is open; bits 7:5 dropped
    if (mode_hit && s.win_st == WDMC_WIN_OPEN) begin
      next_s.mode = reg_wdata[WDMC_MODE_W-1:0];
    end

    // Counter and enable
    if (refresh_exec) begin
      next_s.enabled = 1'b1;
      next_s.count   = '0;
      next_s.flags_out = flags_in;
      next_s.flags_out[WDMC_FLAG_Z] = WDMC_REFRESH_Z;
      next_s.flags_out[WDMC_FLAG_S] = WDMC_REFRESH_S;
      next_s.flags_out[WDMC_FLAG_V] = WDMC_REFRESH_V;
      next_s.flags_we = 1'b1;
    end else if (timeout) begin
      next_s.count        = '0;
      next_s.enabled      = 1'b0;
      next_s.wdt_reset    = 1'b1;
      next_s.por_start    = 1'b1;
      next_s.sleep_exit   = cpu_sleep;
      next_s.restart_addr = WDMC_RESTART_ADDR;
      next_s.mode[WDMC_TSEL_HI:WDMC_TSEL_LO] = WDMC_TSEL_20MS;
      next_s.win_st       = WDMC_WAIT_FIRST;
    end else if (s.enabled && gate_ok && clk_edge) begin
      next_s.count = count_inc;
    end

    // Sleep recovery reopens the window after its first instruction
    if (sleep_recovery && !timeout) begin
      next_s.win_st = WDMC_WAIT_FIRST;
    end

    // Crystal stays on in sleep only to clock the watchdog; otherwise the
    // counter must already be on the RC clock to keep running in sleep
    next_s.crystal_keep_on = next_s.mode[WDMC_SLEEP_BIT]
                             && next_s.mode[WDMC_CLK_BIT];
    next_s.por_clk_sel     = next_s.mode[WDMC_CLK_BIT];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s                 <= '0;
      s.mode            <= WDMC_MODE_RESET;
      s.win_st          <= WDMC_WAIT_FIRST;
      s.restart_addr    <= WDMC_RESTART_ADDR;
    end else begin
      s <= next_s;
    end
  end

  assign flags_out       = s.flags_out;
  assign flags_we        = s.flags_we;
  assign wdt_reset       = s.wdt_reset;
  assign por_start       = s.por_start;
  assign sleep_exit      = s.sleep_exit;
  assign restart_addr    = s.restart_addr;
  assign por_clk_sel     = s.por_clk_sel;
  assign crystal_keep_on = s.crystal_keep_on;
  assign wdt_running     = s.enabled;

endmodule

`default_nettype wire

// >>> tb/wdmc_top_monitor.sv
// Port-level assertion checker for the watchdog mode control block.
// Assumes it is bound to wdmc_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module wdmc_top_monitor (
  input wire logic        mclk,            // Clock
  input wire logic        arst_n,          // Reset
  input wire logic        refresh_exec,    // Refresh
  input wire logic [7:0]  flags_in,        // Flags in
  input wire logic [7:0]  flags_out,       // Flags out
  input wire logic        flags_we,        // Flags strobe
  input wire logic        wdt_reset,       // Time-out pulse
  input wire logic        por_start,       // Delay trigger
  input wire logic        sleep_exit,      // Sleep end
  input wire logic [15:0] restart_addr,    // Restart address
  input wire logic        por_clk_sel,     // Clock select
  input wire logic        crystal_keep_on, // Crystal in sleep
  input wire logic        wdt_running      // Enabled
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_por_pair; wdt_reset == por_start; endproperty
  a_por_pair: assert property (p_por_pair)
    else $error("delay trigger differs from reset pulse");
  property p_pulse; wdt_reset |=> !wdt_reset; endproperty
  a_pulse: assert property (p_pulse)
    else $error("reset pulse longer than one cycle");
  property p_stop; wdt_reset |-> !wdt_running; endproperty
  a_stop: assert property (p_stop)
    else $error("still running at time-out");
  property p_ack; refresh_exec |=> flags_we && wdt_running; endproperty
  a_ack: assert property (p_ack)
    else $error("refresh did not enable");
  property p_flags;
    refresh_exec |=> flags_out[6:4] == 3'b100 && (flags_out & 8'h8F) == ($past(flags_in) & 8'h8F);
  endproperty
  a_flags: assert property (p_flags)
    else $error("refresh flags wrong");
  property p_we_cause; flags_we |-> $past(refresh_exec); endproperty
  a_we_cause: assert property (p_we_cause)
    else $error("flags strobe without refresh");
  property p_restart; restart_addr == 16'h000C; endproperty
  a_restart: assert property (p_restart)
    else $error("restart address wrong");
  property p_sleep; sleep_exit |-> wdt_reset; endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep end without time-out");
  property p_keep; crystal_keep_on |-> por_clk_sel; endproperty
  a_keep: assert property (p_keep)
    else $error("crystal kept on without crystal select");
  property p_fresh; refresh_exec |=> !wdt_reset; endproperty
  a_fresh: assert property (p_fresh)
    else $error("time-out right after refresh");
  property p_idle; !wdt_running && !refresh_exec |=> !wdt_reset; endproperty
  a_idle: assert property (p_idle)
    else $error("time-out while disabled");
endmodule

bind wdmc_top wdmc_top_monitor wdmc_top_monitor_inst (
  .mclk(mclk), .arst_n(arst_n), .refresh_exec(refresh_exec), .flags_in(flags_in),
  .flags_out(flags_out), .flags_we(flags_we), .wdt_reset(wdt_reset),
  .por_start(por_start), .sleep_exit(sleep_exit), .restart_addr(restart_addr),
  .por_clk_sel(por_clk_sel), .crystal_keep_on(crystal_keep_on), .wdt_running(wdt_running));

`default_nettype wire

// >>> tb/watchdog_mode_control_tb.sv
// Self-checking bench for the watchdog mode control block.
// Assumes free-running pin clocks and RC_OSC_KHZ set to 1.
`timescale 1ns/1ps
`default_nettype none

module watchdog_mode_control_tb;
  import wdmc_pkg::*;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        rc_osc_pin = 1'b0;
  logic        crystal_input_pin = 1'b0;
  logic [3:0]  reg_bank = 4'h0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_we = 1'b0;
  logic        refresh_exec = 1'b0;
  logic [7:0]  flags_in = 8'h00;
  logic        first_instr = 1'b0;
  logic        sleep_recovery = 1'b0;
  logic        cpu_idle = 1'b0;
  logic        cpu_sleep = 1'b0;
  logic [7:0]  flags_out;
  logic        flags_we;
  logic        wdt_reset;
  logic        por_start;
  logic        sleep_exit;
  logic [15:0] restart_addr;
  logic        por_clk_sel;
  logic        crystal_keep_on;
  logic        wdt_running;
  int          failures = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          xe = 0;
  int          re = 0;
  int          to_cnt = 0;
  int          mark = 0;

  wdmc_top #(.RC_OSC_KHZ(1)) wdmc_top_inst (
    .mclk(mclk), .arst_n(arst_n), .rc_osc_pin(rc_osc_pin),
    .crystal_input_pin(crystal_input_pin), .reg_bank(reg_bank), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .refresh_exec(refresh_exec),
    .flags_in(flags_in), .first_instr(first_instr), .sleep_recovery(sleep_recovery),
    .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .flags_out(flags_out),
    .flags_we(flags_we), .wdt_reset(wdt_reset), .por_start(por_start),
    .sleep_exit(sleep_exit), .restart_addr(restart_addr), .por_clk_sel(por_clk_sel),
    .crystal_keep_on(crystal_keep_on), .wdt_running(wdt_running));

  always #12.5 mclk = ~mclk;
  always #100 crystal_input_pin = ~crystal_input_pin;
  always #150 rc_osc_pin = ~rc_osc_pin;
  always @(posedge crystal_input_pin) xe++;
  always @(posedge rc_osc_pin) re++;
  always @(negedge mclk) if (wdt_reset === 1'b1) to_cnt++;

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("MISMATCH t=%0t run too long", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Mode register write, bank b, fixed address
  task automatic wr(input logic [3:0] b, input logic [7:0] d);
    @(negedge mclk);
    reg_bank = b;
    reg_addr = 8'h0F;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge mclk);
    reg_we = 1'b0;
    @(negedge mclk);
  endtask

  // Strobe 0 is refresh, 1 is first instruction, 2 is sleep recovery
  task automatic strobe(input int k);
    @(negedge mclk);
    if (k == 0) refresh_exec = 1'b1;
    else if (k == 1) first_instr = 1'b1;
    else sleep_recovery = 1'b1;
    @(negedge mclk);
    refresh_exec = 1'b0;
    first_instr = 1'b0;
    sleep_recovery = 1'b0;
  endtask

  task automatic wait_e(input int n, input logic rc);
    int s;
    s = rc ? re : xe;
    while ((rc ? re : xe) < s + n) @(negedge mclk);
  endtask

  task automatic expect_to(input int lo, input int hi, input logic rc, input logic slp);
    int s;
    int c;
    s = rc ? re : xe;
    c = 0;
    while (wdt_reset !== 1'b1 && c < 20000) begin
      @(negedge mclk);
      c++;
    end
    chk(((rc ? re : xe) - s) inside {[lo:hi]}, 16'h0001, "tap length");
    chk({wdt_reset, por_start, sleep_exit}, {2'b11, slp}, "pulses");
    @(negedge mclk);
    chk({wdt_reset, wdt_running}, 16'h0000, "after time-out");
  endtask

  initial begin
    repeat (4) @(negedge mclk);
    arst_n = 1'b1;
    @(negedge mclk);
    chk(restart_addr, 16'h000C, "restart");
    chk({por_clk_sel, crystal_keep_on, wdt_running}, 16'h0000, "reset state");
    wr(WDMC_BANK_F, 8'h1C);
    chk(por_clk_sel, 16'h0000, "early write");
    $display("test reset and early write done");
    strobe(1);
    wr(4'hE, 8'h1C);
    chk(por_clk_sel, 16'h0000, "wrong bank");
    wr(WDMC_BANK_F, 8'hFC);
    chk({por_clk_sel, crystal_keep_on}, 16'h0003, "mode write");
    wait_e(600, 1'b0);
    chk(to_cnt, 16'h0000, "time-out before enable");
    wr(WDMC_BANK_F, 8'h00);
    chk(por_clk_sel, 16'h0001, "late write");
    $display("test write window done");
    flags_in = 8'hB5;
    strobe(0);
    chk({flags_we, wdt_running}, 16'h0003, "refresh ack");
    chk(flags_out, 16'h00C5, "refresh flags");
    cpu_idle = 1'b1;
    wait_e(300, 1'b0);
    strobe(0);
    expect_to(511, 513, 1'b0, 1'b0);
    cpu_idle = 1'b0;
    $display("test crystal tap done");
    cpu_sleep = 1'b1;
    strobe(0);
    expect_to(1023, 1025, 1'b0, 1'b1);
    cpu_sleep = 1'b0;
    $display("test sleep wake done");
    strobe(1);
    wait_e(120, 1'b0);
    wr(WDMC_BANK_F, 8'h00);
    chk({por_clk_sel, crystal_keep_on}, 16'h0000, "window end write");
    strobe(0);
    mark = to_cnt;
    cpu_idle = 1'b1;
    wait_e(40, 1'b1);
    chk(to_cnt - mark, 16'h0000, "idle suspend");
    cpu_idle = 1'b0;
    cpu_sleep = 1'b1;
    wait_e(40, 1'b1);
    chk(to_cnt - mark, 16'h0000, "sleep suspend");
    cpu_sleep = 1'b0;
    expect_to(8, 11, 1'b1, 1'b0);
    $display("test oscillator tap and gating done");
    strobe(1);
    wr(WDMC_BANK_F, 8'h02);
    strobe(0);
    expect_to(39, 41, 1'b1, 1'b0);
    strobe(1);
    wr(WDMC_BANK_F, 8'h03);
    wait_e(140, 1'b0);
    wr(WDMC_BANK_F, 8'h13);
    chk(por_clk_sel, 16'h0000, "closed write");
    strobe(2);
    wr(WDMC_BANK_F, 8'h13);
    chk(por_clk_sel, 16'h0000, "write before first instruction");
    strobe(1);
    wr(WDMC_BANK_F, 8'h13);
    chk(por_clk_sel, 16'h0001, "reopened write");
    wr(WDMC_BANK_F, 8'h03);
    chk(por_clk_sel, 16'h0000, "last write");
    strobe(0);
    expect_to(159, 161, 1'b1, 1'b0);
    $display("test recovery window and long taps done");
    complete_run();
  end
endmodule

`default_nettype wire
